// ### hw/pcc_program_control.sv
// Program control sequencer, index registers, console run control and APB slave
//
// Behaviour
// - Six index registers; selected one is added to base address for operand.
// - Search codes use the index value as item count, not offset.
// - Index registers do no arithmetic; work happens in staging counter or accumulator.
// - Staging counter is 15 bits; stores, complements, and counts downward only.
// - All index register traffic passes through the staging counter.
// - Address modification adds staging counter into accumulator holding base address.
// - Shift instructions count shift steps down in the staging counter.
// - Multiply and divide track remaining partial steps in the staging counter.
// - Floating-point work uses the staging counter on one operand exponent.
// - Buffer transfers step the buffer address and compare with terminal address.
// - Program counter advances by one after both halves or a skipped lower half.
// - Jumps load the program counter; condition 4-7 first saves the old value.
// - Each instruction is fetch-next then one or more further sequences.
// - Auxiliary sequence covers buffer exchange, clock advance and interrupt entry.
// - Start begins running; another start needs the key back at neutral.
// - Step runs one instruction, halting once the next one is loaded.
// - Step while running enters step mode, halting after the current instruction.
// - Master clear: one action clears peripheral control, the other the processor.
// - Selective stop switches halt at instruction 76; its jump follows a restart.
// - Selective jump switches are jump conditions of instruction 75.
// - Breakpoint matched during fetch halts just before the upper instruction there.
// - Test modes: freeze program counter, or sweep all 32768 storage locations.
// - Index select 7 makes the base address point at the operand address.
// - The address accumulator is 15 bits and adds the staging counter.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ns
module pcc_program_control (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pcc_pkg::pcc_console_t console,
	output pcc_pkg::pcc_stor_req_t stor,
	input wire logic stor_ack,
	input wire logic [47:0] stor_rdata,
	input wire logic io_buf_req,
	input wire logic rtc_tick,
	input wire logic intr_req,
	input wire logic skip_req,
	output logic intr_ack,
	output logic opnd_valid,
	output logic [5:0] opnd_code,
	output logic shift_step,
	output logic arith_step,
	output logic periph_clear,
	output logic halted
);
	import pcc_pkg::*;

	function automatic logic [14:0] add15(input logic [14:0] a, input logic [14:0] b);
		add15 = 15'(a + b);
	endfunction

	function automatic logic [14:0] dec15(input logic [14:0] a);
		dec15 = 15'(a - ONE15);
	endfunction

	function automatic logic in_range(input logic [5:0] f, input logic [5:0] lo,
		input logic [5:0] hi);
		in_range = (f >= lo) && (f <= hi);
	endfunction

	// Condition 0 (and 4) is unconditional; 1-3 and 5-7 test one switch
	function automatic logic sw_cond(input logic [2:0] j, input logic [2:0] sw);
		sw_cond = (j[1:0] == 2'h0) ? 1'b1 : sw[2'(j[1:0] - 2'h1)];
	endfunction

	pcc_console_t cons_s1;
	pcc_console_t cons_s2;
	logic start_prev;
	logic step_prev;
	logic start_ev;
	logic step_ev;
	pcc_state_t state;
	logic [47:0] u;
	logic [14:0] u2;
	logic [14:0] r;
	logic [14:0] p;
	logic [14:0] saved_p;
	logic [14:0] b_reg [1:6];
	logic half_low;
	logic u_loaded;
	logic step_mode;
	logic stop_resume;
	logic bkpt_pass;
	logic [1:0] halt_cause;
	logic [1:0] aux_kind;
	logic aux_phase;
	logic idx_pend;
	logic [2:0] idx_sel;
	logic intr_en;
	logic [14:0] buf_cur;
	logic [14:0] buf_term;
	logic buf_done;
	logic [14:0] rtc;
	logic rtc_pend;
	logic buf_step;
	logic rtc_adv;
	logic wr_en;
	logic [31:0] rd_mux;
	logic rd_ok;
	pcc_instr_t up;
	logic buf_want;

	assign up = pcc_instr_t'(u[47:24]);
	assign halted = state[0];
	assign buf_want = io_buf_req && !buf_done;
	assign wr_en = psel && penable && pready && pwrite;
	assign buf_step = (state == ST_AUX) && (aux_kind == AUX_BUF) && aux_phase;
	assign rtc_adv = (state == ST_AUX) && (aux_kind == AUX_RTC);

	// Console switches are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cons_s1 <= '0;
			cons_s2 <= '0;
			start_prev <= 1'b0;
			step_prev <= 1'b0;
			periph_clear <= 1'b0;
		end
		else
		begin
			cons_s1 <= console;
			cons_s2 <= cons_s1;
			start_prev <= cons_s2.start_key;
			step_prev <= cons_s2.step_key;
			periph_clear <= cons_s2.mclr_periph;
		end
	end

	// key must return to neutral before another start
	assign start_ev = cons_s2.start_key && !start_prev;
	assign step_ev = cons_s2.step_key && !step_prev;

	// APB slave: no wait states, answer prepared during setup
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		rd_ok = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'h0);
		case (paddr[7:0])
			REG_CTRL: rd_mux[CTRL_INTR_EN] = intr_en;
			REG_STATUS: rd_mux = {13'h0000, halt_cause, buf_done, stop_resume, half_low,
				u_loaded, step_mode, state};
			REG_PADDR: rd_mux[14:0] = p;
			REG_SAVED_P: rd_mux[14:0] = saved_p;
			REG_STAGE: rd_mux = {1'b0, u2, 1'b0, r};
			REG_UWORD_HI: rd_mux[15:0] = u[47:32];
			REG_UWORD_LO: rd_mux = u[31:0];
			REG_INDEX: rd_mux[14:0] = r;
			REG_BUF_CUR: rd_mux[14:0] = buf_cur;
			REG_BUF_TERM: rd_mux[14:0] = buf_term;
			REG_RTC: rd_mux[14:0] = rtc;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			intr_en <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !rd_ok;
			prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
			if (wr_en && paddr[7:0] == REG_CTRL)
				intr_en <= pwdata[CTRL_INTR_EN];
		end
	end

	// Peripheral side: buffer addresses and real-time clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_cur <= ZERO15;
			buf_term <= ZERO15;
			buf_done <= 1'b0;
			rtc <= ZERO15;
			rtc_pend <= 1'b0;
		end
		else if (cons_s2.mclr_periph)
		begin
			buf_cur <= ZERO15;
			buf_term <= ZERO15;
			buf_done <= 1'b0;
			rtc <= ZERO15;
			rtc_pend <= 1'b0;
		end
		else
		begin
			if (wr_en && paddr[7:0] == REG_BUF_CUR)
				buf_cur <= pwdata[14:0];
			if (wr_en && paddr[7:0] == REG_BUF_TERM)
				buf_term <= pwdata[14:0];
			if (wr_en && (paddr[7:0] == REG_BUF_CUR || paddr[7:0] == REG_BUF_TERM))
				buf_done <= 1'b0;
			// complement of a down count steps the address up
			if (buf_step)
			begin
				buf_cur <= ~dec15(r);
				if (~dec15(r) == buf_term)
					buf_done <= 1'b1;
			end
			// A tick in the same cycle as the advance is kept
			if (rtc_tick)
				rtc_pend <= 1'b1;
			else if (rtc_adv)
				rtc_pend <= 1'b0;
			if (rtc_adv)
				rtc <= add15(rtc, ONE15);
		end
	end

	// Main sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_HALT;
			u <= 48'h0000_0000_0000;
			u2 <= ZERO15;
			r <= ZERO15;
			p <= ZERO15;
			saved_p <= ZERO15;
			for (int i = 1; i <= 6; i++)
				b_reg[i] <= ZERO15;
			half_low <= 1'b0;
			u_loaded <= 1'b0;
			step_mode <= 1'b0;
			stop_resume <= 1'b0;
			bkpt_pass <= 1'b0;
			halt_cause <= HALT_CONSOLE;
			aux_kind <= AUX_BUF;
			aux_phase <= 1'b0;
			idx_pend <= 1'b0;
			idx_sel <= 3'h0;
			stor <= '0;
			intr_ack <= 1'b0;
			opnd_valid <= 1'b0;
			opnd_code <= 6'h00;
			shift_step <= 1'b0;
			arith_step <= 1'b0;
		end
		else if (cons_s2.mclr_cpu)
		begin
			state <= ST_HALT;
			u <= 48'h0000_0000_0000;
			u2 <= ZERO15;
			r <= ZERO15;
			p <= ZERO15;
			saved_p <= ZERO15;
			for (int i = 1; i <= 6; i++)
				b_reg[i] <= ZERO15;
			half_low <= 1'b0;
			u_loaded <= 1'b0;
			step_mode <= 1'b0;
			stop_resume <= 1'b0;
			bkpt_pass <= 1'b0;
			halt_cause <= HALT_CONSOLE;
			aux_phase <= 1'b0;
			idx_pend <= 1'b0;
			stor <= '0;
			intr_ack <= 1'b0;
			opnd_valid <= 1'b0;
			shift_step <= 1'b0;
			arith_step <= 1'b0;
		end
		else
		begin
			intr_ack <= 1'b0;
			opnd_valid <= 1'b0;
			shift_step <= 1'b0;
			arith_step <= 1'b0;
			// step while running halts at the end of this instruction
			if (step_ev)
				step_mode <= 1'b1;
			else if (start_ev && state == ST_HALT)
				step_mode <= 1'b0;
			case (state)
				ST_HALT:
				begin
					// software reaches index registers only via the staging counter
					if (idx_pend)
					begin
						b_reg[idx_sel] <= r;
						idx_pend <= 1'b0;
					end
					else if (wr_en && paddr[7:0] == REG_INDEX &&
						pwdata[IDX_SEL_LSB+2:IDX_SEL_LSB] != 3'h0 &&
						pwdata[IDX_SEL_LSB+2:IDX_SEL_LSB] <= B_LAST)
					begin
						idx_sel <= pwdata[IDX_SEL_LSB+2:IDX_SEL_LSB];
						if (pwdata[IDX_READ_BIT])
							r <= b_reg[pwdata[IDX_SEL_LSB+2:IDX_SEL_LSB]];
						else
						begin
							r <= pwdata[14:0];
							idx_pend <= 1'b1;
						end
					end
					else if (wr_en && paddr[7:0] == REG_PADDR)
					begin
						p <= pwdata[14:0];
						half_low <= 1'b0;
						u_loaded <= 1'b0;
						stop_resume <= 1'b0;
					end
					else if (start_ev || step_ev)
					begin
						halt_cause <= HALT_CONSOLE;
						if (cons_s2.test_sweep)
						begin
							stor.addr <= ZERO15;
							state <= ST_SWEEP;
						end
						// jump of a selective stop is taken on restart
						else if (stop_resume)
							state <= ST_EXEC;
						// the loaded instruction runs, then the next is loaded
						else if (u_loaded)
							state <= ST_XFER;
						else
							state <= ST_FETCH;
					end
				end
				ST_FETCH:
				begin
					if (!stor.req)
					begin
						// auxiliary sub-sequences are taken between words
						if (buf_want || rtc_pend || (intr_en && intr_req))
						begin
							aux_kind <= buf_want ? AUX_BUF : (rtc_pend ? AUX_RTC : AUX_INTR);
							aux_phase <= 1'b0;
							state <= ST_AUX;
						end
						// stop before the upper instruction of the matching word
						else if (cons_s2.bkpt_en && !bkpt_pass && p == cons_s2.bkpt_addr)
						begin
							bkpt_pass <= 1'b1;
							halt_cause <= HALT_BKPT;
							state <= ST_HALT;
						end
						else
						begin
							stor.req <= 1'b1;
							stor.addr <= p;
						end
					end
					else if (stor_ack)
					begin
						stor.req <= 1'b0;
						u <= stor_rdata;
						u2 <= stor_rdata[38:24];
						half_low <= 1'b1;
						u_loaded <= 1'b1;
						bkpt_pass <= 1'b0;
						state <= step_mode ? ST_HALT : ST_XFER;
					end
				end
				ST_XFER:
				begin
					if (up.b == B_INDIRECT)
						state <= ST_INDIR;
					else
					begin
						// selected index register (none for select 0)
						// index value enters the staging counter first
						r <= (up.b == 3'h0) ? ZERO15 : b_reg[up.b];
						// search keeps the index value as an item count
						state <= in_range(up.f, OP_SEARCH_LO, OP_SEARCH_HI) ? ST_EXEC : ST_ADDM;
					end
				end
				ST_INDIR:
				begin
					if (!stor.req)
					begin
						stor.req <= 1'b1;
						stor.addr <= u2;
					end
					else if (stor_ack)
					begin
						stor.req <= 1'b0;
						u2 <= stor_rdata[14:0];
						state <= ST_EXEC;
					end
				end
				// 15-bit accumulator adds the staging counter
				// index arithmetic done here, never in the index register
				ST_ADDM:
				begin
					u2 <= add15(u2, r);
					state <= ST_EXEC;
				end
				ST_EXEC:
				begin
					if (up.f == OP_FAULT_LO || up.f == OP_FAULT_HI)
					begin
						halt_cause <= HALT_FAULT;
						state <= ST_HALT;
					end
					// jump loads P; condition 4-7 saves the old P
					// only a switch at 1 counts as set; a resumed selective stop jumps regardless
					else if ((up.f == OP_SEL_JUMP && sw_cond(up.b, cons_s2.sel_jump)) ||
						(up.f == OP_SEL_STOP && stop_resume))
					begin
						if (up.b[2])
							saved_p <= p;
						p <= u2;
						stop_resume <= 1'b0;
						half_low <= 1'b0;
						u_loaded <= 1'b0;
						state <= ST_FETCH;
					end
					// matching stop switch halts the processor
					else if (up.f == OP_SEL_STOP && sw_cond(up.b, cons_s2.sel_stop))
					begin
						stop_resume <= 1'b1;
						halt_cause <= HALT_SEL_STOP;
						state <= ST_HALT;
					end
					else if (up.f == OP_SEL_JUMP || up.f == OP_SEL_STOP)
						state <= ST_END;
					// shift count is the modified address
					else if (in_range(up.f, OP_SHIFT_LO, OP_SHIFT_HI))
					begin
						r <= u2;
						state <= ST_COUNT;
					end
					else if (in_range(up.f, OP_MULDIV_LO, OP_MULDIV_HI))
					begin
						r <= MULDIV_STEPS;
						state <= ST_COUNT;
					end
					else if (in_range(up.f, OP_SEARCH_LO, OP_SEARCH_HI))
						state <= ST_COUNT;
					else
						state <= ST_OPND;
				end
				ST_COUNT:
				begin
					if (r == ZERO15)
						state <= ST_END;
					else
					begin
						r <= dec15(r);
						shift_step <= in_range(up.f, OP_SHIFT_LO, OP_SHIFT_HI);
						arith_step <= !in_range(up.f, OP_SHIFT_LO, OP_SHIFT_HI);
					end
				end
				ST_OPND:
				begin
					if (!stor.req)
					begin
						stor.req <= 1'b1;
						stor.addr <= u2;
					end
					else if (stor_ack)
					begin
						stor.req <= 1'b0;
						opnd_valid <= 1'b1;
						opnd_code <= up.f;
						// exponent of the operand goes into the staging counter
						if (in_range(up.f, OP_FLOAT_LO, OP_FLOAT_HI))
						begin
							r <= {4'h0, stor_rdata[46:36]};
							state <= ST_FLT;
						end
						else
							state <= ST_END;
					end
				end
				ST_FLT:
				begin
					u2 <= add15(u2, r);
					state <= ST_END;
				end
				// lower half moves up, else P advances by one
				ST_END:
				begin
					if (half_low && !skip_req)
					begin
						u[47:24] <= u[23:0];
						u2 <= u[14:0];
						half_low <= 1'b0;
						state <= step_mode ? ST_HALT : ST_XFER;
					end
					else
					begin
						// hold mode repeats the same word
						if (!cons_s2.test_hold)
							p <= add15(p, ONE15);
						half_low <= 1'b0;
						u_loaded <= 1'b0;
						state <= ST_FETCH;
					end
				end
				// buffer step, clock advance, interrupt entry
				ST_AUX:
				begin
					if (aux_kind == AUX_BUF && !aux_phase)
					begin
						r <= ~buf_cur;
						aux_phase <= 1'b1;
					end
					else
					begin
						if (aux_kind == AUX_BUF)
							r <= dec15(r);
						if (aux_kind == AUX_INTR)
						begin
							saved_p <= p;
							p <= INTR_VECTOR;
							half_low <= 1'b0;
							u_loaded <= 1'b0;
							intr_ack <= 1'b1;
						end
						aux_phase <= 1'b0;
						state <= ST_FETCH;
					end
				end
				ST_SWEEP:
				begin
					// Stop only between reads so no request is cut short
					if (stor.req)
					begin
						if (stor_ack)
						begin
							stor.req <= 1'b0;
							stor.addr <= add15(stor.addr, ONE15);
						end
					end
					else if (!cons_s2.test_sweep || step_mode)
						state <= ST_HALT;
					else
						stor.req <= 1'b1;
				end
				default: state <= ST_HALT;
			endcase
		end
	end
endmodule

// ### hw/pcc_pkg.sv
// Shared constants and types for the program control and console block
package pcc_pkg;
	localparam int ADDR_W = 15;
	localparam int WORD_W = 48;

	// Operation codes (octal 14, 64-67, 75, 76, 00, 77)
	localparam logic [5:0] OP_FAULT_LO = 6'h00;
	localparam logic [5:0] OP_FAULT_HI = 6'h3f;
	localparam logic [5:0] OP_ADD = 6'h0c;
	localparam logic [5:0] OP_SEARCH_LO = 6'h34;
	localparam logic [5:0] OP_SEARCH_HI = 6'h37;
	localparam logic [5:0] OP_SEL_JUMP = 6'h3d;
	localparam logic [5:0] OP_SEL_STOP = 6'h3e;
	localparam logic [5:0] OP_SHIFT_LO = 6'h01;
	localparam logic [5:0] OP_SHIFT_HI = 6'h03;
	localparam logic [5:0] OP_MULDIV_LO = 6'h14;
	localparam logic [5:0] OP_MULDIV_HI = 6'h17;
	localparam logic [5:0] OP_FLOAT_LO = 6'h18;
	localparam logic [5:0] OP_FLOAT_HI = 6'h1b;
	localparam logic [2:0] B_INDIRECT = 3'h7;
	localparam logic [2:0] B_LAST = 3'h6;

	localparam logic [14:0] MULDIV_STEPS = 15'h002f;
	localparam logic [14:0] INTR_VECTOR = 15'h0001;
	localparam logic [14:0] ZERO15 = 15'h0000;
	localparam logic [14:0] ONE15 = 15'h0001;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PADDR = 8'h08;
	localparam logic [7:0] REG_SAVED_P = 8'h0c;
	localparam logic [7:0] REG_STAGE = 8'h10;
	localparam logic [7:0] REG_UWORD_HI = 8'h14;
	localparam logic [7:0] REG_UWORD_LO = 8'h18;
	localparam logic [7:0] REG_INDEX = 8'h1c;
	localparam logic [7:0] REG_BUF_CUR = 8'h20;
	localparam logic [7:0] REG_BUF_TERM = 8'h24;
	localparam logic [7:0] REG_RTC = 8'h28;

	// Field positions
	localparam int CTRL_INTR_EN = 0;
	localparam int IDX_SEL_LSB = 16;
	localparam int IDX_READ_BIT = 20;
	localparam int STAGE_U2_LSB = 16;

	localparam logic [1:0] HALT_CONSOLE = 2'h0;
	localparam logic [1:0] HALT_FAULT = 2'h1;
	localparam logic [1:0] HALT_SEL_STOP = 2'h2;
	localparam logic [1:0] HALT_BKPT = 2'h3;

	localparam logic [1:0] AUX_BUF = 2'h0;
	localparam logic [1:0] AUX_RTC = 2'h1;
	localparam logic [1:0] AUX_INTR = 2'h2;

	typedef enum logic [11:0] {
		ST_HALT = 12'h001,
		ST_FETCH = 12'h002,
		ST_XFER = 12'h004,
		ST_INDIR = 12'h008,
		ST_ADDM = 12'h010,
		ST_EXEC = 12'h020,
		ST_COUNT = 12'h040,
		ST_OPND = 12'h080,
		ST_FLT = 12'h100,
		ST_END = 12'h200,
		ST_AUX = 12'h400,
		ST_SWEEP = 12'h800
	} pcc_state_t;

	typedef struct packed {
		logic start_key;
		logic step_key;
		logic mclr_periph;
		logic mclr_cpu;
		logic [2:0] sel_stop;
		logic [2:0] sel_jump;
		logic bkpt_en;
		logic [14:0] bkpt_addr;
		logic test_hold;
		logic test_sweep;
	} pcc_console_t;

	typedef struct packed {
		logic [5:0] f;
		logic [2:0] b;
		logic [14:0] m;
	} pcc_instr_t;

	typedef struct packed {
		logic req;
		logic [14:0] addr;
	} pcc_stor_req_t;
endpackage

// ### sim/pcc_assertions.sv
// Port-level checker for the program control block
`timescale 1ns/1ns
module pcc_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire pcc_pkg::pcc_console_t console,
	input wire pcc_pkg::pcc_stor_req_t stor,
	input wire logic stor_ack,
	input wire logic opnd_valid,
	input wire logic periph_clear,
	input wire logic halted
);
	import pcc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_apb_answer;
		psel && !penable |=> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("pready missing after setup");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_rdata_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
	property p_req_hold;
		stor.req && !stor_ack |=> stor.req && $stable(stor.addr);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("storage request dropped early");
	property p_req_drop;
		stor_ack |=> !stor.req;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("storage request kept after ack");
	property p_halt_quiet;
		halted |-> !stor.req;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("storage request while halted");
	property p_opnd_pulse;
		opnd_valid |=> !opnd_valid;
	endproperty
	a_opnd_pulse: assert property (p_opnd_pulse) else $error("operand pulse too long");
	property p_clear_follow;
		$rose(console.mclr_periph) |-> ##[1:4] periph_clear;
	endproperty
	a_clear_follow: assert property (p_clear_follow) else $error("peripheral clear missing");
	sequence s_keys_idle;
		(halted && !console.start_key && !console.step_key) [*5];
	endsequence
	property p_no_restart;
		s_keys_idle |=> halted;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("left halt without a key");
	c_err: cover property (pslverr);
	c_opnd: cover property (opnd_valid);
	c_clear: cover property (periph_clear);
	c_stop: cover property ($rose(halted));
endmodule
bind pcc_program_control pcc_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.console(console), .stor(stor), .stor_ack(stor_ack), .opnd_valid(opnd_valid),
	.periph_clear(periph_clear), .halted(halted));

// ### sim/pcc_store_model.sv
// Storage responder with random latency for the program control block
`timescale 1ns/1ns
module pcc_store_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire pcc_pkg::pcc_stor_req_t stor,
	output logic stor_ack,
	output logic [47:0] stor_rdata
);
	import pcc_pkg::*;
	logic [47:0] mem [int];
	int log_q [$];
	int wait_n;
	// Idle data toggles so a stale word is never mistaken for an answer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stor_ack <= 1'b0;
			stor_rdata <= 48'h0;
			wait_n <= 0;
		end
		else
		begin
			stor_ack <= 1'b0;
			stor_rdata <= ~stor_rdata;
			if (stor.req && !stor_ack)
			begin
				if (wait_n == 0)
				begin
					stor_ack <= 1'b1;
					stor_rdata <= mem.exists(int'(stor.addr)) ? mem[int'(stor.addr)] : 48'h0;
					log_q.push_back(int'(stor.addr));
					wait_n <= int'($urandom_range(3, 0));
				end
				else
					wait_n <= wait_n - 1;
			end
		end
	end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the program control block
`timescale 1ns/1ns
module testbench;
	import pcc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, stor_ack, intr_ack, opnd_valid, shift_step, arith_step;
	logic periph_clear, halted;
	logic [5:0] opnd_code;
	logic [47:0] stor_rdata;
	pcc_console_t con = '0;
	pcc_stor_req_t stor;
	int err_count = 0;
	int checks = 0;
	int opnd_n = 0;
	int shift_n = 0;
	int arith_n = 0;
	logic rtc_tick = 1'b0;
	int exp_q [$];
	logic [31:0] rd, rnd;
	logic er;
	always #50 pclk = ~pclk;
	always @(posedge pclk)
	begin
		if (opnd_valid === 1'b1)
			opnd_n <= opnd_n + 1;
		if (shift_step === 1'b1)
			shift_n <= shift_n + 1;
		if (arith_step === 1'b1)
			arith_n <= arith_n + 1;
	end
	pcc_program_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .console(con), .stor(stor), .stor_ack(stor_ack),
		.stor_rdata(stor_rdata), .io_buf_req(1'b0), .rtc_tick(rtc_tick), .intr_req(1'b0),
		.skip_req(1'b0), .intr_ack(intr_ack), .opnd_valid(opnd_valid), .opnd_code(opnd_code),
		.shift_step(shift_step), .arith_step(arith_step), .periph_clear(periph_clear),
		.halted(halted));
	pcc_store_model i_mem (.pclk(pclk), .presetn(presetn), .stor(stor), .stor_ack(stor_ack),
		.stor_rdata(stor_rdata));
	task print_verdict;
		if (err_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			err_count++;
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// key back to neutral after each press
	task press(input int k);
		@(posedge pclk);
		{con.start_key, con.step_key, con.mclr_periph, con.mclr_cpu} <= 4'h8 >> k;
		repeat (6) @(posedge pclk);
		{con.start_key, con.step_key, con.mclr_periph, con.mclr_cpu} <= 4'h0;
		repeat (6) @(posedge pclk);
	endtask
	task wait_halt;
		int n;
		n = 0;
		while (halted !== 1'b1 && n < 5000)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 5000)
		begin
			err_count++;
			print_verdict();
		end
	endtask
	task run(input logic [31:0] pa);
		press(3);
		apb(1'b1, REG_PADDR, pa);
		i_mem.log_q.delete();
		press(0);
		wait_halt();
	endtask
	task run_free(input logic [31:0] pa);
		press(3);
		apb(1'b1, REG_PADDR, pa);
		i_mem.log_q.delete();
		press(0);
		repeat (60) @(posedge pclk);
		press(1);
		wait_halt();
	endtask
	task cmp_log;
		chk(i_mem.log_q.size(), exp_q.size());
		for (int i = 0; i < exp_q.size(); i++)
			chk(i_mem.log_q[i], exp_q[i]);
	endtask
	task cause(input logic [1:0] c);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({30'h0, rd[18:17]}, {30'h0, c});
	endtask
	initial
	begin
		void'($urandom(32'h00e0));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_STATUS, 32'h0);
		chk({20'h0, rd[11:0]}, 32'h1);
		apb(1'b0, REG_PADDR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		rnd = $urandom();
		apb(1'b1, REG_CTRL, rnd);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, {31'h0, rnd[0]});
		rnd = $urandom_range(32767, 0);
		apb(1'b1, REG_PADDR, rnd);
		apb(1'b0, REG_PADDR, 32'h0);
		chk(rd, rnd);
		apb(1'b1, REG_INDEX, 32'h0003_0020);
		apb(1'b1, REG_INDEX, 32'h0001_0005);
		apb(1'b0, REG_INDEX, 32'h0);
		chk(rd, 32'h5);
		apb(1'b1, REG_INDEX, 32'h0013_0000);
		apb(1'b0, REG_INDEX, 32'h0);
		chk(rd, 32'h20);
		// Indexed add pair then fault word, no clear so index values survive
		i_mem.mem[32'h10] = {OP_ADD, 3'h3, 15'h0100, OP_ADD, 3'h0, 15'h0200};
		apb(1'b1, REG_PADDR, 32'h10);
		press(0);
		wait_halt();
		exp_q = '{32'h10, 32'h120, 32'h200, 32'h11};
		cmp_log();
		chk(opnd_n, 32'h2);
		chk({26'h0, opnd_code}, {26'h0, OP_ADD});
		cause(HALT_FAULT);
		con.sel_stop <= 3'h1;
		i_mem.mem[32'h40] = {OP_SEL_STOP, 3'h1, 15'h0200, 24'h0};
		run(32'h40);
		exp_q = '{32'h40};
		cmp_log();
		cause(HALT_SEL_STOP);
		press(0);
		wait_halt();
		exp_q = '{32'h40, 32'h200};
		cmp_log();
		con.sel_stop <= 3'h0;
		i_mem.mem[32'h50] = {OP_SEL_JUMP, 3'h6, 15'h0300, 24'h0};
		for (int s = 0; s < 2; s++)
		begin
			con.sel_jump <= (s == 1) ? 3'h2 : 3'h0;
			run(32'h50);
			exp_q = {32'h50};
			if (s == 1)
				exp_q.push_back(32'h300);
			cmp_log();
		end
		apb(1'b0, REG_SAVED_P, 32'h0);
		chk(rd, 32'h50);
		i_mem.mem[32'h60] = 48'h0;
		for (int b = 0; b < 2; b++)
		begin
			con.bkpt_en <= 1'b1;
			con.bkpt_addr <= 15'h0060 + 15'(b);
			run(32'h60);
			exp_q = {};
			if (b == 1)
				exp_q.push_back(32'h60);
			cmp_log();
			cause((b == 1) ? HALT_FAULT : HALT_BKPT);
		end
		con.bkpt_en <= 1'b0;
		// Latched clock tick is served ahead of the next fetch
		rtc_tick <= 1'b1;
		@(posedge pclk);
		rtc_tick <= 1'b0;
		i_mem.mem[32'h70] = {OP_SHIFT_LO, 3'h0, 15'h0005, OP_MULDIV_LO, 3'h0, 15'h0000};
		run(32'h70);
		exp_q = {32'h70, 32'h71};
		cmp_log();
		chk(shift_n, 32'h5);
		chk(arith_n, 32'(MULDIV_STEPS));
		apb(1'b0, REG_RTC, 32'h0);
		chk(rd, 32'h1);
		con.test_hold <= 1'b1;
		i_mem.mem[32'h80] = {OP_ADD, 3'h0, 15'h0001, OP_ADD, 3'h0, 15'h0002};
		run_free(32'h80);
		chk(i_mem.log_q[3], 32'h80);
		con.test_hold <= 1'b0;
		con.test_sweep <= 1'b1;
		run_free(32'h0);
		for (int i = 0; i < 3; i++)
			chk(i_mem.log_q[i], i);
		cause(HALT_CONSOLE);
		con.test_sweep <= 1'b0;
		press(2);
		print_verdict();
	end
endmodule
